// ### hdl/pot_nv_store.v
/*
 * the sixteen-byte nonvolatile store modelled as a register memory with one
 * write port and one registered read port.
 * assumes programming time is handled outside; writes land in one cycle.
 */
`timescale 1ns/1ps
`include "pot_cmd_consts.vh"

module pot_nv_store #(
    parameter DEPTH = `NV_DEPTH,
    parameter AW = 4,
    parameter DW = 8
) (
    input wire i_mclk, // system clock
    input wire i_rst_n, // async reset, active low
    input wire i_wr, // write strobe
    input wire [AW-1:0] i_waddr, // write address
    input wire [DW-1:0] i_wdata, // write data
    input wire [AW-1:0] i_raddr, // read address
    output reg [DW-1:0] o_rdata // registered read data
);

    reg [DW-1:0] mem_q [0:DEPTH-1];
    integer k;

    ////////////////////////////////////////////////////////////////////////
    // reset stands in for the factory preset; real parts keep contents
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem_q[k] <= `NV_FACTORY;
            end
            o_rdata <= {DW{1'b0}};
        end else begin
            if (i_wr) begin
                mem_q[i_waddr] <= i_wdata;
            end
            o_rdata <= mem_q[i_raddr];
        end
    end

endmodule // pot_nv_store

// ### hdl/pot_serial_command_decoder.v
/*
 * serial command decoder of a dual-channel digital potentiometer: holds the
 * two wiper registers, executes the sixteen commands on chip select rise and
 * drives the open-drain serial output.
 * assumes the link pins arrive asynchronous to i_mclk and the serial clock
 * runs well below a quarter of i_mclk.
 */
// Notes on behaviour
// - frame is command, address, data, 16 bits
// - serial out passes previous frame bits through
// - readback byte lands in low shift byte
// - step and shift commands ignore data byte
// - commands execute only on select rising
// - wipers load from store at power on
// - code 0 changes nothing, returns to idle
// - code 1 store to wiper, read power state
// - code 2 saves wiper into store
// - code 3 writes data byte to store
// - codes 4/5 right shift, floor zero
// - codes 6/7 decrement, floor zero
// - code 8 with address 0 reloads every wiper from store
// - code 9 store byte to shift register
// - code 10 wiper byte to shift register
// - code 11 data byte into wiper
// - codes 12/13 left shift, ceiling all ones
// - codes 14/15 increment, ceiling all ones
// - frames shift most significant bit first
// - select pulse without clock repeats last command
// - left shift: zero to one, midscale up to full
// - serial output released while select high
`timescale 1ns/1ps
`include "pot_cmd_consts.vh"

module pot_serial_command_decoder #(
    parameter DW = 8
) (
    input wire i_mclk, // system clock, 20 MHz
    input wire i_rst_n, // async reset, active low
    input wire i_sclk, // serial clock pin
    input wire i_cs_n, // chip select pin, active low
    input wire i_sdi, // serial data in pin
    output wire o_sdo, // serial data out, open-drain level
    output wire o_sdo_oe, // high while pulling the pin low
    output reg [DW-1:0] o_wiper0, // wiper register, channel 0
    output reg [DW-1:0] o_wiper1, // wiper register, channel 1
    output reg [1:0] o_power_state, // idle, active or read state
    output reg o_ready // boot load finished
);

    ////////////////////////////////////////////////////////////////////////
    // wiper arithmetic helpers

    // one 6 dB step down; zero stays zero
    function [DW-1:0] shr_sat;
        input [DW-1:0] v;
        begin
            shr_sat = v >> 1;
        end
    endfunction

    // one 6 dB step up with the log-friendly corrections
    function [DW-1:0] shl_sat;
        input [DW-1:0] v;
        begin
            if (v == `WIPER_ZERO) begin
                shl_sat = `WIPER_ONE;
            end else if (v >= `WIPER_MID) begin
                shl_sat = `WIPER_FULL;
            end else begin
                shl_sat = {v[DW-2:0], 1'b0};
            end
        end
    endfunction

    function [DW-1:0] dec_sat;
        input [DW-1:0] v;
        begin
            dec_sat = (v == `WIPER_ZERO) ? v : v - 1'b1;
        end
    endfunction

    function [DW-1:0] inc_sat;
        input [DW-1:0] v;
        begin
            inc_sat = (v == `WIPER_FULL) ? v : v + 1'b1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // signals
    wire [`FRAME_BITS-1:0] word;
    wire [`CNT_W-1:0] bit_count;
    wire frame_end;
    wire sdo_bit;
    wire [DW-1:0] nv_rdata;
    reg nv_wr;
    reg [3:0] nv_waddr;
    reg [DW-1:0] nv_wdata;
    reg [3:0] nv_raddr;
    reg load_q;
    reg [`FRAME_BITS-1:0] load_word_q;
    reg [1:0] boot_q;
    reg [1:0] exec_q; // 0 idle, 1 wait read data, 2 apply
    reg [`FRAME_BITS-1:0] cmd_q; // latched command word
    reg [`FRAME_BITS-1:0] last_cmd_q; // last executed word
    reg have_last_q;
    reg reload_q; // slot 1 step of a reload pending

    wire [3:0] cmd = cmd_q[`CMD_MSB:`CMD_LSB];
    wire [3:0] addr = cmd_q[`ADDR_MSB:`ADDR_LSB];
    wire [DW-1:0] data = cmd_q[`DATA_MSB:`DATA_LSB];
    wire chan = cmd_q[`ADDR_LSB];

    localparam EX_IDLE = 2'h0;
    localparam EX_WAIT = 2'h1;
    localparam EX_APPLY = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // leaf instances
    pot_serial_shifter #(
        .W(`FRAME_BITS)
    ) u_shift (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_sdi(i_sdi),
        .i_load(load_q),
        .i_load_word(load_word_q),
        .o_word(word),
        .o_count(bit_count),
        .o_frame_end(frame_end),
        .o_sdo(sdo_bit)
    );

    pot_nv_store #(
        .DEPTH(`NV_DEPTH),
        .AW(4),
        .DW(DW)
    ) u_store (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr(nv_wr),
        .i_waddr(nv_waddr),
        .i_wdata(nv_wdata),
        .i_raddr(nv_raddr),
        .o_rdata(nv_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // open drain: pull low only for a zero bit while selected
    assign o_sdo = 1'b0;
    assign o_sdo_oe = ~sdo_bit; // shifter parks sdo high when deselected

    ////////////////////////////////////////////////////////////////////////
    // store read address: boot reads wiper slots, commands read their target
    always @* begin
        nv_raddr = `NV_ADDR_WIPER0;
        if (boot_q == `BOOT_LOAD1) begin
            nv_raddr = `NV_ADDR_WIPER1;
        end else if (boot_q == `BOOT_DONE) begin
            if (cmd == `CMD_READ_NV) begin
                nv_raddr = addr;
            end else begin
                nv_raddr = {3'h0, chan};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame acceptance, boot load and command execution
    // a frame that is not a whole number of nibbles is dropped, which
    // guards against a noisy clock leaving a half-shifted word behind
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wiper0 <= `WIPER_ZERO;
            o_wiper1 <= `WIPER_ZERO;
            o_power_state <= `PWR_IDLE;
            o_ready <= 1'b0;
            boot_q <= `BOOT_LOAD0;
            exec_q <= EX_IDLE;
            cmd_q <= {`FRAME_BITS{1'b0}};
            last_cmd_q <= {`FRAME_BITS{1'b0}};
            have_last_q <= 1'b0;
            reload_q <= 1'b0;
            nv_wr <= 1'b0;
            nv_waddr <= 4'h0;
            nv_wdata <= {DW{1'b0}};
            load_q <= 1'b0;
            load_word_q <= {`FRAME_BITS{1'b0}};
        end else begin
            nv_wr <= 1'b0;
            load_q <= 1'b0;
            case (boot_q)
            `BOOT_LOAD0: begin
                boot_q <= `BOOT_LOAD1; // read data for slot 0 next cycle
            end
            `BOOT_LOAD1: begin
                o_wiper0 <= nv_rdata;
                boot_q <= `BOOT_DONE;
            end
            `BOOT_DONE: begin
                o_ready <= 1'b1;
                if (!o_ready) begin
                    o_wiper1 <= nv_rdata;
                end
            end
            default: begin
                boot_q <= `BOOT_LOAD0;
            end
            endcase

            case (exec_q)
            EX_IDLE: begin
                if (frame_end && o_ready) begin
                    if (bit_count == {`CNT_W{1'b0}}) begin
                        if (have_last_q) begin
                            cmd_q <= last_cmd_q;
                            exec_q <= EX_WAIT;
                        end
                    end else if ((bit_count & `CNT_NIBBLE_MASK) == {`CNT_W{1'b0}}) begin
                        cmd_q <= word; // last 16 bits in are ours
                        exec_q <= EX_WAIT;
                    end
                end
            end
            EX_WAIT: begin
                exec_q <= EX_APPLY; // registered store read settles
            end
            EX_APPLY: begin
                exec_q <= EX_IDLE;
                // a reload's slot 1 step must not become the repeated command
                last_cmd_q <= reload_q ? last_cmd_q : cmd_q;
                reload_q <= 1'b0;
                have_last_q <= 1'b1;
                o_power_state <= `PWR_ACTIVE;
                case (cmd)
                `CMD_NOP: begin
                    o_power_state <= `PWR_IDLE;
                end
                `CMD_NV_TO_WIPER: begin
                    if (chan) o_wiper1 <= nv_rdata; else o_wiper0 <= nv_rdata;
                    o_power_state <= reload_q ? `PWR_ACTIVE : `PWR_READ;
                end
                `CMD_WIPER_TO_NV: begin
                    nv_wr <= 1'b1;
                    nv_waddr <= {3'h0, chan};
                    nv_wdata <= chan ? o_wiper1 : o_wiper0;
                end
                `CMD_DATA_TO_NV: begin
                    nv_wr <= 1'b1;
                    nv_waddr <= addr;
                    nv_wdata <= data;
                end
                `CMD_SHR_ONE: begin
                    if (chan) o_wiper1 <= shr_sat(o_wiper1); else o_wiper0 <= shr_sat(o_wiper0);
                end
                `CMD_SHR_ALL: begin
                    o_wiper0 <= shr_sat(o_wiper0);
                    o_wiper1 <= shr_sat(o_wiper1);
                end
                `CMD_DEC_ONE: begin
                    if (chan) o_wiper1 <= dec_sat(o_wiper1); else o_wiper0 <= dec_sat(o_wiper0);
                end
                `CMD_DEC_ALL: begin
                    o_wiper0 <= dec_sat(o_wiper0);
                    o_wiper1 <= dec_sat(o_wiper1);
                end
                `CMD_RELOAD_ALL: begin
                    if (addr == `NV_ADDR_WIPER0) begin
                        o_wiper0 <= nv_rdata; // slot 0 read here
                        exec_q <= EX_WAIT;
                        cmd_q[`CMD_MSB:`CMD_LSB] <= `CMD_NV_TO_WIPER;
                        cmd_q[`ADDR_MSB:`ADDR_LSB] <= `NV_ADDR_WIPER1; // then slot 1
                        reload_q <= 1'b1;
                    end
                end
                `CMD_READ_NV: begin
                    load_q <= 1'b1;
                    load_word_q <= {cmd_q[`CMD_MSB:`ADDR_LSB], nv_rdata};
                end
                `CMD_READ_WIPER: begin
                    load_q <= 1'b1;
                    load_word_q <= {cmd_q[`CMD_MSB:`ADDR_LSB], chan ? o_wiper1 : o_wiper0};
                end
                `CMD_DATA_TO_WIPER: begin
                    if (chan) o_wiper1 <= data; else o_wiper0 <= data;
                end
                `CMD_SHL_ONE: begin
                    if (chan) o_wiper1 <= shl_sat(o_wiper1); else o_wiper0 <= shl_sat(o_wiper0);
                end
                `CMD_SHL_ALL: begin
                    o_wiper0 <= shl_sat(o_wiper0);
                    o_wiper1 <= shl_sat(o_wiper1);
                end
                `CMD_INC_ONE: begin
                    if (chan) o_wiper1 <= inc_sat(o_wiper1); else o_wiper0 <= inc_sat(o_wiper0);
                end
                `CMD_INC_ALL: begin
                    o_wiper0 <= inc_sat(o_wiper0);
                    o_wiper1 <= inc_sat(o_wiper1);
                end
                default: begin
                    o_power_state <= o_power_state;
                end
                endcase
            end
            default: begin
                exec_q <= EX_IDLE;
            end
            endcase
        end
    end

endmodule // pot_serial_command_decoder

// ### hdl/pot_serial_shifter.v
/*
 * serial front end: synchronises the link pins, finds clock edges and
 * shifts a 16-bit word msb first; reports each frame end.
 * assumes spi mode 0 or 3 timing: sample on rising, shift out on falling.
 */
`timescale 1ns/1ps
`include "pot_cmd_consts.vh"

module pot_serial_shifter #(
    parameter W = `FRAME_BITS
) (
    input wire i_mclk, // system clock
    input wire i_rst_n, // async reset, active low
    input wire i_sclk, // serial clock pin
    input wire i_cs_n, // chip select pin, active low
    input wire i_sdi, // serial data pin
    input wire i_load, // load word from decoder
    input wire [W-1:0] i_load_word, // word to load
    output reg [W-1:0] o_word, // shift register contents
    output reg [`CNT_W-1:0] o_count, // bits shifted this frame
    output reg o_frame_end, // pulse on chip select rise
    output reg o_sdo // serial output bit
);

    reg [2:0] sclk_s_q;
    reg [2:0] cs_s_q;
    reg [1:0] sdi_s_q;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;
    wire cs_low;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers; third stage only for edge detection
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s_q <= 3'h0;
            cs_s_q <= 3'h7;
            sdi_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], i_sclk};
            cs_s_q <= {cs_s_q[1:0], i_cs_n};
            sdi_s_q <= {sdi_s_q[0], i_sdi};
        end
    end

    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    assign cs_low = ~cs_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    // shift msb first; word stays after frame for daisy chain out
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word <= {W{1'b0}};
            o_count <= {`CNT_W{1'b0}};
            o_frame_end <= 1'b0;
            o_sdo <= 1'b1;
        end else begin
            o_frame_end <= cs_rise;
            if (i_load) begin
                o_word <= i_load_word;
            end else if (cs_low && sclk_rise) begin
                o_word <= {o_word[W-2:0], sdi_s_q[1]};
                o_count <= o_count + 1'b1;
            end
            if (o_frame_end) begin
                o_count <= {`CNT_W{1'b0}};
            end
            // msb presented while select low, updated on falling edge
            if (!cs_low) begin
                o_sdo <= 1'b1;
            end else if (sclk_fall || (cs_s_q[2] && !cs_s_q[1])) begin
                o_sdo <= o_word[W-1];
            end
        end
    end

endmodule // pot_serial_shifter

// ### include/pot_cmd_consts.vh
/*
 * constants for the serial command decoder of a dual-channel potentiometer.
 * assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef POT_CMD_CONSTS_VH
`define POT_CMD_CONSTS_VH

// frame layout
`define FRAME_BITS 16
`define CMD_MSB 15
`define CMD_LSB 12
`define ADDR_MSB 11
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
// six bits so a 32-bit chained frame is not taken for a bare select pulse
`define CNT_W 6
`define CNT_NIBBLE_MASK 6'h03

// command codes
`define CMD_NOP 4'h0
`define CMD_NV_TO_WIPER 4'h1
`define CMD_WIPER_TO_NV 4'h2
`define CMD_DATA_TO_NV 4'h3
`define CMD_SHR_ONE 4'h4
`define CMD_SHR_ALL 4'h5
`define CMD_DEC_ONE 4'h6
`define CMD_DEC_ALL 4'h7
`define CMD_RELOAD_ALL 4'h8
`define CMD_READ_NV 4'h9
`define CMD_READ_WIPER 4'hA
`define CMD_DATA_TO_WIPER 4'hB
`define CMD_SHL_ONE 4'hC
`define CMD_SHL_ALL 4'hD
`define CMD_INC_ONE 4'hE
`define CMD_INC_ALL 4'hF

// store addresses and reset values
`define NV_ADDR_WIPER0 4'h0
`define NV_ADDR_WIPER1 4'h1
`define NV_DEPTH 16
`define NV_FACTORY 8'h80
`define WIPER_ZERO 8'h00
`define WIPER_FULL 8'hFF
`define WIPER_MID 8'h80
`define WIPER_ONE 8'h01

// power states
`define PWR_IDLE 2'h0
`define PWR_ACTIVE 2'h1
`define PWR_READ 2'h2

// boot sequencer states
`define BOOT_LOAD0 2'h0
`define BOOT_LOAD1 2'h1
`define BOOT_DONE 2'h2

`endif

// ### verif/pot_decoder_monitor.sv
/*
 * port checker for the potentiometer command decoder.
 * assumes it is bound to pot_serial_command_decoder and sees one clock domain.
 */
`timescale 1ns/1ps

module pot_decoder_monitor #(
    parameter DW = 8
) (
    input logic i_mclk, // system clock
    input logic i_rst_n, // async reset, active low
    input logic i_sclk, // serial clock pin
    input logic i_cs_n, // chip select pin
    input logic i_sdi, // serial data in
    input logic o_sdo, // open-drain data level
    input logic o_sdo_oe, // pull-down enable
    input logic [DW-1:0] o_wiper0, // wiper register 0
    input logic [DW-1:0] o_wiper1, // wiper register 1
    input logic [1:0] o_power_state, // power state
    input logic o_ready // boot load done
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////
    // select high for three samples: only then may a command land
    sequence cs_quiet3;
        $past(i_cs_n, 1) && $past(i_cs_n, 2) && $past(i_cs_n, 3);
    endsequence
    // select idle long enough for the sync chain to settle
    sequence cs_idle6;
        i_cs_n [*6];
    endsequence

    ////////////////////////////////////////////////////////////////
    chk_sdo_release: assert property ($rose(i_cs_n) |-> ##[1:5] !o_sdo_oe)
        else $error("sdo still pulled after select rise");
    chk_sdo_idle: assert property (cs_idle6 |-> !o_sdo_oe)
        else $error("sdo pulled while select idle");
    chk_sdo_level: assert property (o_sdo_oe |-> !o_sdo)
        else $error("open-drain output driving high");
    chk_wiper_quiet: assert property (!$stable(o_wiper0) || !$stable(o_wiper1) |-> cs_quiet3)
        else $error("wiper changed while frame in progress");
    chk_power_quiet: assert property (!$stable(o_power_state) |-> cs_quiet3)
        else $error("power state changed while frame in progress");
    chk_ready_hold: assert property (o_ready |=> o_ready)
        else $error("ready dropped");
    chk_ready_soon: assert property ($rose(i_rst_n) |-> ##[1:4] o_ready)
        else $error("boot load too slow");
    chk_boot_idle: assert property (!o_ready |-> o_power_state == 2'h0)
        else $error("power state left idle before boot done");
endmodule // pot_decoder_monitor

bind pot_serial_command_decoder pot_decoder_monitor #(.DW(DW)) u_mon (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_wiper0(o_wiper0),
    .o_wiper1(o_wiper1), .o_power_state(o_power_state), .o_ready(o_ready)
);

// ### verif/pot_spi_host_model.sv
/*
 * host controller model: spi master, mode 0, 400 ns serial clock.
 * assumes i_sdo_line is the resolved open-drain wire with its pull-up.
 */
`timescale 1ns/1ps

module pot_spi_host_model (
    input logic i_mclk, // system clock, paces the link
    input logic i_sdo_line, // resolved serial out wire
    output logic o_sclk, // serial clock, low outside frames
    output logic o_cs_n, // chip select
    output logic o_sdi, // serial data to device
    output logic [31:0] o_rx // bits seen on sdo this frame
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
        o_rx = 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    // all changes land just after an mclk edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // n bits msb first; n of 0 is a bare select pulse
    task automatic frame(input logic [31:0] w, input int n);
        o_rx = 32'h0;
        o_cs_n = 1'b0;
        wait_clk(4);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = w[i];
            wait_clk(4);
            o_rx = {o_rx[30:0], i_sdo_line}; // sample as sclk rises
            o_sclk = 1'b1;
            wait_clk(4);
            o_sclk = 1'b0;
        end
        wait_clk(4);
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // stale data must not pass for held data
        wait_clk(12); // gap covers execution and the next-fall spacing
    endtask
endmodule // pot_spi_host_model

// ### verif/testbench.sv
/*
 * self-checking bench for the potentiometer command decoder.
 * assumes the store powers up at 8'h80 and sdo has a pull-up.
 */
`timescale 1ns/1ps

module testbench;
    logic i_mclk, i_rst_n;
    wire sclk, cs_n, sdi, sdo_line, o_sdo, o_sdo_oe, o_ready;
    wire [7:0] o_wiper0, o_wiper1;
    wire [1:0] o_power_state;
    wire [31:0] rx;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] nv [16];
    logic [7:0] we [2];
    logic [15:0] exp_out;
    bit have_prev = 0;

    assign sdo_line = o_sdo_oe ? o_sdo : 1'b1; // pull-up when released

    pot_serial_command_decoder #(.DW(8)) u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_wiper0(o_wiper0),
        .o_wiper1(o_wiper1), .o_power_state(o_power_state), .o_ready(o_ready));
    pot_spi_host_model u_host (.i_mclk(i_mclk), .i_sdo_line(sdo_line), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_sdi(sdi), .o_rx(rx));

    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] step(input logic [3:0] c, input logic [7:0] v);
        case (c)
            4'h4, 4'h5: step = v >> 1;
            4'h6, 4'h7: step = (v == 8'h00) ? 8'h00 : v - 8'h01;
            4'hC, 4'hD: step = (v == 8'h00) ? 8'h01 : (v >= 8'h80) ? 8'hFF : v << 1;
            default: step = (v == 8'hFF) ? 8'hFF : v + 8'h01;
        endcase
    endfunction

    // each frame after the first also checks that sdo replayed the previous word
    task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
        u_host.frame({16'h0, c, a, d}, 16);
        if (have_prev) check("sdo word", {16'h0, exp_out}, rx);
        have_prev = 1;
        exp_out = {c, a, d};
    endtask

    task automatic check_w;
        check("wiper0", {24'h0, we[0]}, {24'h0, o_wiper0});
        check("wiper1", {24'h0, we[1]}, {24'h0, o_wiper1});
    endtask

    task automatic load(input logic [7:0] a, input logic [7:0] b);
        send(4'hB, 4'h0, a);
        send(4'hB, 4'h1, b);
        we[0] = a;
        we[1] = b;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_boot;
        check("ready", 32'h1, {31'h0, o_ready});
        check_w();
    endtask

    task automatic t_load_save;
        load(8'h40, 8'hC3);
        check_w();
        send(4'h2, 4'h0, 8'hA5);
        send(4'h2, 4'h1, 8'h00);
        nv[0] = 8'h40;
        nv[1] = 8'hC3;
        load(8'h13, 8'h31);
        send(4'h1, 4'h0, 8'hFF);
        we[0] = nv[0];
        check_w();
        check("power", 32'h2, {30'h0, o_power_state});
        send(4'h0, 4'hF, 8'hFF);
        check_w();
        check("power", 32'h0, {30'h0, o_power_state});
    endtask

    task automatic t_steps;
        logic [3:0] codes [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
        logic [7:0] lo [3] = '{8'h00, 8'h80, 8'h01};
        logic [7:0] hi [3] = '{8'hFF, 8'h7F, 8'hFE};
        foreach (codes[i]) begin
            for (int k = 0; k < 3; k++) begin
                load(lo[k], hi[k]);
                send(codes[i], 4'h1, 8'hA5);
                if (codes[i][0]) we[0] = step(codes[i], we[0]);
                we[1] = step(codes[i], we[1]);
                check_w();
            end
        end
    endtask

    task automatic t_repeat;
        load(8'h10, 8'h20);
        send(4'hE, 4'h0, 8'h00);
        u_host.frame(32'h0, 0); // bare select pulse
        we[0] = 8'h12;
        check_w();
    endtask

    task automatic t_readback;
        for (int a = 0; a < 16; a++) begin
            if (a >= 2) begin
                send(4'h3, a[3:0], {~a[3:0], a[3:0]});
                nv[a] = {~a[3:0], a[3:0]};
            end
            send(4'h9, a[3:0], 8'h00);
            exp_out = {4'h9, a[3:0], nv[a]};
            send(4'h0, 4'h0, 8'h00);
        end
        send(4'hA, 4'h1, 8'h00);
        exp_out = {8'hA1, we[1]};
        send(4'h0, 4'h0, 8'h00);
    endtask

    task automatic t_reload;
        load(8'h11, 8'h22);
        send(4'h8, 4'h0, 8'h00);
        we[0] = nv[0];
        we[1] = nv[1];
        check_w();
        check("power", 32'h1, {30'h0, o_power_state});
    endtask

    // two chained words: only the later one belongs to this device
    task automatic t_chain;
        u_host.frame({16'hB077, 16'hB1EE}, 32);
        check("chain head", {16'h0, exp_out}, {16'h0, rx[31:16]});
        check("chain tail", 32'hB077, {16'h0, rx[15:0]});
        exp_out = 16'hB1EE;
        we[1] = 8'hEE;
        check_w();
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // hang guard: a stalled run ends as a failure
    initial begin
        repeat (60000) @(posedge i_mclk);
        mismatches++;
        conclude();
    end

    initial begin
        i_rst_n = 1'b0;
        foreach (nv[i]) nv[i] = 8'h80;
        we[0] = 8'h80;
        we[1] = 8'h80;
        repeat (5) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        repeat (6) @(posedge i_mclk);
        #1;
        t_boot();
        t_load_save();
        t_steps();
        t_repeat();
        t_readback();
        t_reload();
        t_chain();
        conclude();
    end
endmodule // testbench
